// file: rtl/osd_char_mem.sv
// glyph pattern store and banked video window of the on-screen text unit
// assumes cpu and display generator run on clk_sys; no pin inputs here

// Behaviour
// R01: glyph store answers program addresses 3000H to 4FDFH only.
// R02: software must not place code inside the glyph store range.
// R03: generator finds a glyph only through a video item's pattern-select value.
// R04: store holds 4080 steps, two 16-bit words each, 8160 words.
// R05: a glyph is 16x16 dots, one step per row, 16 steps.
// R06: low 8 bits of each step are dummy ones, never displayed.
// R07: character part is 8 bits per step, one means lit.
// R08: each character bit drives two adjacent dots.
// R09: 16-bit rim field is overlaid dot by dot on the expanded row.
// R10: video window is data bank 2, 00H-3FH, only while window select is set.
// R11: window offsets 30H-3FH store nothing, ignore writes, read zero.
// R12: 14 video banks; nibble at bank 2 address 73H picks the visible one.
// R13: items are 12 bits over three nibbles; 48 nibbles per bank.
// R14: total video capacity holds at least 223 items.
// R15: item MSB is the identifier, remaining 11 bits the data field.
// R16: items classify as glyph select, carriage return or control data.
// R17: glyph index is item bits 7-0, colour bits 10-8.
// R18: window select is bit 3 of the display mode register.
// R19: glyph n occupies 32 words starting at 3000H plus 20H times n.
// R20: first item nibble holds bits 11-8, second 7-4, third 3-0.
module osd_char_mem
	import osd_pkg::*;
#(
	parameter int NUM_BANKS = VBANKS,
	parameter int NUM_WORDS = STORE_WORDS
)(
	// clock, reset, enable
	input  wire logic          clk_sys,
	input  wire logic          srst,
	input  wire logic          ce,
	// program memory side
	input  wire logic          pm_wr_en,
	input  wire logic          pm_rd_en,
	input  wire logic [15:0]   pm_addr,
	input  wire logic [15:0]   pm_wdata,
	output logic      [15:0]   pm_rdata,
	output logic               pm_hit,
	// data memory side
	input  wire logic          dm_wr_en,
	input  wire logic          dm_rd_en,
	input  wire logic [3:0]    dm_bank,
	input  wire logic [6:0]    dm_addr,
	input  wire logic [3:0]    dm_wdata,
	output logic      [3:0]    dm_rdata,
	output logic               dm_hit,
	// display mode register value and bank status
	input  wire logic [3:0]    mode_sel,
	output logic      [3:0]    bank_sel,
	// display generator fetch
	input  wire logic          gen_req,
	input  wire osd_fetch_type gen_fetch,
	output logic               gen_valid,
	output osd_item_type       gen_item,
	output logic      [15:0]   gen_dots
);

	localparam int VNIBS = NUM_BANKS * BANK_NIBBLES;

	// ********************************
	// elaboration checks
	// ********************************
	if (NUM_BANKS < 1 || NUM_BANKS > 16) begin : g_chk_banks
		$error("osd_char_mem: NUM_BANKS must be 1..16");
	end
	if (VNIBS / ITEM_NIBBLES < ITEMS_MIN) begin : g_chk_items // R14
		$error("osd_char_mem: video capacity below item minimum");
	end
	if (NUM_WORDS < GLYPHS * GLYPH_WORDS || NUM_WORDS > 8192) begin : g_chk_words
		$error("osd_char_mem: NUM_WORDS cannot hold every glyph");
	end

	// ********************************
	// storage arrays
	// ********************************
	logic [15:0] store_mem [NUM_WORDS];
	logic [3:0]  vram_mem  [VNIBS];

	// ********************************
	// program memory decode
	// ********************************
	logic        pm_in;
	logic [12:0] pm_idx;
	logic [15:0] pm_rdata_r, pm_rdata_nxt;
	logic        pm_hit_r, pm_hit_nxt;

	// anything outside the window is ordinary code space and left alone
	assign pm_in  = (pm_addr >= STORE_BASE) && (pm_addr <= STORE_LAST); // R01 R02
	assign pm_idx = 13'(pm_addr - STORE_BASE); // R04

	// glyph definition writes; memory has no reset, contents are software's
	always_ff @(posedge clk_sys) begin
		if (ce && pm_wr_en && pm_in) begin
			store_mem[pm_idx] <= pm_wdata; // R01
		end
	end

	// read port: one cycle, hit pulses only for store addresses
	always_comb begin
		pm_hit_nxt   = pm_rd_en && pm_in; // R01
		pm_rdata_nxt = pm_rdata_r;
		if (pm_rd_en) begin
			pm_rdata_nxt = pm_in ? store_mem[pm_idx] : 16'h0000;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pm_rdata_r <= 16'h0000;
			pm_hit_r   <= 1'b0;
		end else if (ce) begin
			pm_rdata_r <= pm_rdata_nxt;
			pm_hit_r   <= pm_hit_nxt;
		end
	end

	// ********************************
	// data memory window decode
	// ********************************
	logic       win_on, dm_b2, in_win, in_item, in_gap, is_bsel, bank_ok;
	logic [9:0] cpu_nib;
	logic [3:0] bank_sel_r, bank_sel_nxt;
	logic [3:0] dm_rdata_r, dm_rdata_nxt;
	logic       dm_hit_r, dm_hit_nxt;

	assign win_on  = mode_sel[MODE_WIN_BIT]; // R18
	assign dm_b2   = dm_bank == VRAM_DM_BANK;
	assign in_win  = dm_b2 && win_on && dm_addr <= WIN_LAST; // R10
	assign in_item = in_win && dm_addr < WIN_GAP; // R13
	assign in_gap  = in_win && !in_item; // R11
	assign is_bsel = dm_b2 && dm_addr == BANKSEL_ADDR;
	// bank codes 14 and 15 select nothing: writes dropped, reads zero
	assign bank_ok = {1'b0, bank_sel_r} < 5'(NUM_BANKS); // R12
	assign cpu_nib = nib_index(bank_sel_r, dm_addr[5:0]); // R13

	// item nibbles; the gap above 2FH never reaches the array
	always_ff @(posedge clk_sys) begin
		if (ce && dm_wr_en && in_item && bank_ok) begin
			vram_mem[cpu_nib] <= dm_wdata; // R10 R11
		end
	end

	// bank register and read answer
	always_comb begin
		bank_sel_nxt = bank_sel_r;
		if (dm_wr_en && is_bsel) begin
			bank_sel_nxt = dm_wdata; // R12
		end
		dm_hit_nxt   = dm_rd_en && (in_win || is_bsel);
		dm_rdata_nxt = dm_rdata_r;
		if (dm_rd_en) begin
			if (is_bsel) begin
				dm_rdata_nxt = bank_sel_r;
			end else if (in_item && bank_ok) begin
				dm_rdata_nxt = vram_mem[cpu_nib];
			end else begin
				dm_rdata_nxt = 4'h0; // R11
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bank_sel_r <= BANKSEL_RST;
			dm_rdata_r <= 4'h0;
			dm_hit_r   <= 1'b0;
		end else if (ce) begin
			bank_sel_r <= bank_sel_nxt;
			dm_rdata_r <= dm_rdata_nxt;
			dm_hit_r   <= dm_hit_nxt;
		end
	end

	// ********************************
	// generator stage 1: item fetch
	// ********************************
	logic [9:0]   gen_nib;
	logic [11:0]  gen_raw;
	logic         gen_bank_ok;
	osd_item_type dec_item;
	logic         s1_valid_r, s1_valid_nxt;
	osd_item_type s1_item_r, s1_item_nxt;
	logic [3:0]   s1_row_r, s1_row_nxt;

	assign gen_bank_ok = {1'b0, gen_fetch.bank} < 5'(NUM_BANKS);
	assign gen_nib     = nib_index(gen_fetch.bank, {2'b00, gen_fetch.slot} * 6'd3); // R13

	// first nibble is the top of the item; missing banks read as zero
	always_comb begin
		gen_raw = 12'h000;
		if (gen_bank_ok) begin
			gen_raw = {vram_mem[gen_nib], vram_mem[10'(gen_nib + 10'd1)],
				vram_mem[10'(gen_nib + 10'd2)]}; // R20
		end
	end

	osd_item_decode u_dec (
		.item_raw  (gen_raw),
		.ctrl_slot (gen_fetch.ctrl_slot),
		.item      (dec_item)
	);

	always_comb begin
		s1_valid_nxt = gen_req;
		s1_item_nxt  = gen_req ? dec_item : s1_item_r;
		s1_row_nxt   = gen_req ? gen_fetch.row : s1_row_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1_valid_r <= 1'b0;
			s1_item_r  <= '0;
			s1_row_r   <= 4'h0;
		end else if (ce) begin
			s1_valid_r <= s1_valid_nxt;
			s1_item_r  <= s1_item_nxt;
			s1_row_r   <= s1_row_nxt;
		end
	end

	// ********************************
	// generator stage 2: glyph row
	// ********************************
	logic         glyph_ok;
	logic [12:0]  w_hi, w_lo;
	logic [15:0]  step_hi, step_lo, exp_dots;
	logic         gen_valid_r, gen_valid_nxt;
	osd_item_type gen_item_r, gen_item_nxt;
	logic [15:0]  gen_dots_r, gen_dots_nxt;

	// code FFH has no glyph behind it, so the row stays dark
	assign glyph_ok = s1_item_r.cls == ITEM_GLYPH && s1_item_r.glyph < 8'(GLYPHS); // R03
	assign w_hi     = glyph_ok ? glyph_word(s1_item_r.glyph, s1_row_r, 1'b0) : 13'h0; // R19 R05
	assign w_lo     = glyph_ok ? glyph_word(s1_item_r.glyph, s1_row_r, 1'b1) : 13'h0; // R19
	assign step_hi  = store_mem[w_hi];
	// step_lo[7:0] is the dummy byte and is never looked at
	assign step_lo  = store_mem[w_lo]; // R06

	osd_row_expand #(
		.CW (CHAR_BITS)
	) u_exp (
		.char_bits (step_hi[15:CHAR_LSB]), // R07
		.rim_bits  ({step_hi[CHAR_LSB-1:0], step_lo[15:RIM_LO_LSB]}), // R09
		.show      (glyph_ok),
		.dots      (exp_dots)
	);

	always_comb begin
		gen_valid_nxt = s1_valid_r;
		gen_item_nxt  = s1_valid_r ? s1_item_r : gen_item_r;
		gen_dots_nxt  = s1_valid_r ? exp_dots : gen_dots_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			gen_valid_r <= 1'b0;
			gen_item_r  <= '0;
			gen_dots_r  <= 16'h0000;
		end else if (ce) begin
			gen_valid_r <= gen_valid_nxt;
			gen_item_r  <= gen_item_nxt;
			gen_dots_r  <= gen_dots_nxt;
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign pm_rdata  = pm_rdata_r;
	assign pm_hit    = pm_hit_r;
	assign dm_rdata  = dm_rdata_r;
	assign dm_hit    = dm_hit_r;
	assign bank_sel  = bank_sel_r;
	assign gen_valid = gen_valid_r;
	assign gen_item  = gen_item_r;
	assign gen_dots  = gen_dots_r;

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst || !ce);

	sequence s_fetch;
		gen_req ##1 s1_valid_r;
	endsequence

	a_store_range: assert property (pm_rd_en |=> pm_hit == $past(pm_in)) // R01
		else $error("store hit does not follow address range");
	a_store_write: assert property (pm_wr_en && pm_in ##1 pm_rd_en && $stable(pm_addr)
		|=> pm_rdata == $past(pm_wdata, 2)) // R04
		else $error("store word not read back");
	a_glyph_addr: assert property (glyph_ok |-> w_lo == 13'(w_hi + 13'd1)
		&& w_hi == 13'({5'h00, s1_item_r.glyph} * 13'd32 + {8'h00, s1_row_r, 1'b0})) // R19
		else $error("glyph step address wrong");
	a_row_dots: assert property (s1_valid_r && !glyph_ok |=> gen_valid && gen_dots == 16'h0) // R03
		else $error("non-glyph item lit dots");
	a_fetch_time: assert property (s_fetch |=> gen_valid) // R05
		else $error("fetch answer late");
	a_dot_pairs: assert property (gen_valid |-> (gen_dots[15:8] & ~$past(step_hi[7:0]))
		== ({{2{$past(step_hi[15])}}, {2{$past(step_hi[14])}}, {2{$past(step_hi[13])}},
		{2{$past(step_hi[12])}}} & ~$past(step_hi[7:0])) || !$past(glyph_ok)) // R08
		else $error("character bit not doubled");
	a_gap_zero: assert property (dm_rd_en && in_gap |=> dm_hit && dm_rdata == 4'h0) // R11
		else $error("gap read not zero");
	a_win_off: assert property (dm_rd_en && dm_b2 && !win_on && dm_addr <= WIN_LAST
		|=> !dm_hit) // R10 R18
		else $error("window answered while deselected");
	a_bank_write: assert property (dm_wr_en && is_bsel |=> bank_sel == $past(dm_wdata)) // R12
		else $error("bank select not taken");
	a_colour: assert property (gen_valid && gen_item.cls == ITEM_GLYPH
		|-> gen_item.colour == gen_item.raw[10:8] && gen_item.glyph == gen_item.raw[7:0]) // R17
		else $error("glyph fields misplaced");
	a_page_cr: assert property (s1_valid_r && s1_item_r.raw == 12'h7FF
		&& s1_item_r.cls != ITEM_CTRL |-> s1_item_r.cr == CR_PAGE) // R16
		else $error("screen return not recognised");

endmodule // osd_char_mem

// file: rtl/osd_pkg.sv
// shared constants, types and helpers of the on-screen text memory map
// assumes one clock domain; all users import osd_pkg::*
package osd_pkg;

	// ********************************
	// glyph pattern store placement
	// ********************************
	localparam logic [15:0] STORE_BASE  = 16'h3000;
	localparam logic [15:0] STORE_LAST  = 16'h4FDF;
	localparam int          STORE_WORDS = 8160;
	localparam int          STORE_STEPS = 4080;
	localparam int          GLYPHS      = 255;
	localparam int          GLYPH_ROWS  = 16;
	localparam int          GLYPH_WORDS = 32;
	localparam int          CHAR_BITS   = 8;
	// step layout over its two words: char in hi[15:8], rim hi[7:0] + lo[15:8]
	localparam int          CHAR_LSB    = 8;
	localparam int          RIM_LO_LSB  = 8;

	// ********************************
	// video window placement
	// ********************************
	localparam logic [3:0]  VRAM_DM_BANK  = 4'h2;
	localparam logic [6:0]  WIN_GAP       = 7'h30;
	localparam logic [6:0]  WIN_LAST      = 7'h3F;
	localparam logic [6:0]  BANKSEL_ADDR  = 7'h73;
	localparam logic [3:0]  BANKSEL_RST   = 4'h0;
	localparam int          VBANKS        = 14;
	localparam int          BANK_NIBBLES  = 48;
	localparam int          ITEM_NIBBLES  = 3;
	localparam int          ITEMS_MIN     = 223;
	localparam int          MODE_WIN_BIT  = 3;

	// ********************************
	// video item fields
	// ********************************
	localparam int          ITEM_ID_BIT  = 11;
	localparam int          COLOUR_LSB   = 8;
	localparam int          COLOUR_MSB   = 10;
	localparam logic [10:0] CR_PTR_RESET = 11'h5FF;
	localparam logic [10:0] CR_LINE      = 11'h6FF;
	localparam logic [10:0] CR_SCREEN    = 11'h7FF;

	typedef enum logic [1:0] {ITEM_GLYPH, ITEM_CR, ITEM_CTRL} osd_class_type;
	typedef enum logic [1:0] {CR_NONE, CR_PTR, CR_ROW, CR_PAGE} osd_cr_type;

	typedef struct packed {
		osd_class_type cls;
		osd_cr_type    cr;
		logic          ctrl2_next;
		logic [2:0]    colour;
		logic [7:0]    glyph;
		logic [11:0]   raw;
	} osd_item_type;

	typedef struct packed {
		logic [3:0] bank;
		logic [3:0] slot;
		logic [3:0] row;
		logic       ctrl_slot;
	} osd_fetch_type;

	// word offset of one half of a glyph step inside the store
	function automatic logic [12:0] glyph_word(logic [7:0] g, logic [3:0] r, logic half);
		return {g, r, half};
	endfunction

	// nibble index of a bank offset inside the flat video array
	function automatic logic [9:0] nib_index(logic [3:0] bank, logic [5:0] off);
		return ({6'h00, bank} * 10'd48) + {4'h0, off};
	endfunction

endpackage

// file: rtl/osd_item_decode.sv
// classifies one 12-bit video item and splits its fields
// assumes the caller says whether the slot is a control slot
module osd_item_decode
	import osd_pkg::*;
(
	// item in
	input  wire logic [11:0]  item_raw,
	input  wire logic         ctrl_slot,
	// decoded item
	output osd_item_type      item
);

	// ********************************
	// classification
	// ********************************
	// control slots are known only from sequence, so that wins over patterns
	always_comb begin
		item            = '0;
		item.raw        = item_raw;
		item.cls        = ITEM_GLYPH;
		item.cr         = CR_NONE;
		if (ctrl_slot) begin
			item.cls = ITEM_CTRL; // R16
		end else if (!item_raw[ITEM_ID_BIT] && item_raw[10:0] == CR_SCREEN) begin
			item.cls = ITEM_CR; // R16
			item.cr  = CR_PAGE;
		end else if (!item_raw[ITEM_ID_BIT] && item_raw[10:0] == CR_LINE) begin
			item.cls = ITEM_CR;
			item.cr  = CR_ROW;
		end else if (!item_raw[ITEM_ID_BIT] && item_raw[10:0] == CR_PTR_RESET) begin
			item.cls = ITEM_CR;
			item.cr  = CR_PTR;
		end else begin
			item.glyph      = item_raw[7:0]; // R17
			item.colour     = item_raw[COLOUR_MSB:COLOUR_LSB]; // R17
			item.ctrl2_next = item_raw[ITEM_ID_BIT]; // R15
		end
	end

endmodule // osd_item_decode

// file: rtl/osd_row_expand.sv
// widens one row of character bits and lays the rim over it
// purely combinational; the caller registers the result
module osd_row_expand
	import osd_pkg::*;
#(
	parameter int CW = CHAR_BITS
)(
	// row in
	input  wire logic [CW-1:0]   char_bits,
	input  wire logic [2*CW-1:0] rim_bits,
	input  wire logic            show,
	// dots out, bit 2*CW-1 leftmost
	output logic      [2*CW-1:0] dots
);

	if (CW < 1) begin : g_chk
		$error("osd_row_expand: CW must be positive");
	end

	// ********************************
	// doubling and overlay
	// ********************************
	// one character bit lights two neighbouring dots, rim ORs on top
	always_comb begin
		dots = '0;
		for (int i = 0; i < CW; i++) begin
			dots[2*i]   = char_bits[i]; // R08
			dots[2*i+1] = char_bits[i]; // R08
		end
		dots = show ? (dots | rim_bits) : '0; // R09
	end

endmodule // osd_row_expand

// file: dv/osd_cpu_model.sv
// on-chip cpu model: program and data memory accesses toward the text memory block
// assumes the bench owns clk_sys; requests launch on the falling edge
module osd_cpu_model
	import osd_pkg::*;
(
	// clock
	input  wire logic        clk_sys,
	// program memory side
	output logic             pm_wr_en,
	output logic             pm_rd_en,
	output logic      [15:0] pm_addr,
	output logic      [15:0] pm_wdata,
	input  wire logic [15:0] pm_rdata,
	input  wire logic        pm_hit,
	// data memory side
	output logic             dm_wr_en,
	output logic             dm_rd_en,
	output logic      [3:0]  dm_bank,
	output logic      [6:0]  dm_addr,
	output logic      [3:0]  dm_wdata,
	input  wire logic [3:0]  dm_rdata,
	input  wire logic        dm_hit
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// idle bus
	// ********************************
	initial begin
		{pm_wr_en, pm_rd_en, dm_wr_en, dm_rd_en} = 4'h0;
		{pm_addr, pm_wdata} = 32'h0;
		{dm_bank, dm_addr, dm_wdata} = 15'h0;
	end

	// one program access; released lines flip so stale values never look valid
	task automatic pm_access(input logic wr, input logic [15:0] a, input logic [15:0] wd,
			output logic [15:0] rd, output logic hit);
		@(negedge clk_sys);
		pm_wr_en = wr;
		pm_rd_en = !wr;
		pm_addr = a;
		pm_wdata = wd;
		@(negedge clk_sys);
		rd = pm_rdata;
		hit = pm_hit;
		pm_wr_en = 1'b0;
		pm_rd_en = 1'b0;
		pm_addr = ~a;
		pm_wdata = ~wd;
	endtask

	// write then read of one word in back-to-back cycles
	task automatic pm_write_read(input logic [15:0] a, input logic [15:0] wd,
			output logic [15:0] rd, output logic hit);
		@(negedge clk_sys);
		pm_wr_en = 1'b1;
		pm_addr = a;
		pm_wdata = wd;
		@(negedge clk_sys);
		pm_wr_en = 1'b0;
		pm_rd_en = 1'b1;
		@(negedge clk_sys);
		rd = pm_rdata;
		hit = pm_hit;
		pm_rd_en = 1'b0;
		pm_addr = ~a;
		pm_wdata = ~wd;
	endtask

	// one data memory nibble access
	task automatic dm_access(input logic wr, input logic [3:0] b, input logic [6:0] a,
			input logic [3:0] wd, output logic [3:0] rd, output logic hit);
		@(negedge clk_sys);
		dm_wr_en = wr;
		dm_rd_en = !wr;
		dm_bank = b;
		dm_addr = a;
		dm_wdata = wd;
		@(negedge clk_sys);
		rd = dm_rdata;
		hit = dm_hit;
		dm_wr_en = 1'b0;
		dm_rd_en = 1'b0;
		dm_addr = ~a;
		dm_wdata = ~wd;
	endtask

	// glyph row definition; this task puts only glyph data into the store range
	task automatic define_row(input logic [7:0] g, input logic [3:0] r, input logic [7:0] ch,
			input logic [15:0] rim);
		logic [15:0] a;
		logic [15:0] rd;
		logic        hit;
		a = STORE_BASE + {3'h0, g, 5'h00} + {11'h000, r, 1'b0};
		pm_access(1'b1, a, {ch, rim[15:8]}, rd, hit);
		pm_access(1'b1, a + 16'h0001, {rim[7:0], 8'hFF}, rd, hit);
	endtask

	// select a video bank, then store one item high nibble first
	task automatic write_item(input logic [3:0] b, input logic [3:0] k, input logic [11:0] v);
		logic [3:0] rd;
		logic       hit;
		dm_access(1'b1, VRAM_DM_BANK, BANKSEL_ADDR, b, rd, hit);
		for (int i = 0; i < 3; i++) begin
			dm_access(1'b1, VRAM_DM_BANK, 7'(3 * k + i), v[11 - 4 * i -: 4], rd, hit);
		end
	endtask
endmodule // osd_cpu_model

// file: dv/osd_char_mem_test.sv
// self-checking bench of the glyph store and video window
// assumes one 100 MHz clock; bench inputs change on the falling edge
module osd_char_mem_test
	import osd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// stimulus and wiring
	// ********************************
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic [3:0] mode_sel = 4'h0;
	logic gen_req = 1'b0;
	osd_fetch_type gen_fetch = '0;
	logic pm_wr_en, pm_rd_en, pm_hit, dm_wr_en, dm_rd_en, dm_hit, gen_valid;
	logic [15:0] pm_addr, pm_wdata, pm_rdata, gen_dots;
	logic [3:0] dm_bank, dm_wdata, dm_rdata, bank_sel;
	logic [6:0] dm_addr;
	osd_item_type gen_item;
	int failures = 0;
	int compares = 0;
	logic [15:0] rd16;
	logic [3:0] rd4;
	logic hit;

	always #5 clk_sys = ~clk_sys;

	osd_char_mem #(.NUM_BANKS(VBANKS), .NUM_WORDS(STORE_WORDS)) u_osd_char_mem (
		.clk_sys(clk_sys), .srst(srst), .ce(ce),
		.pm_wr_en(pm_wr_en), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
		.pm_rdata(pm_rdata), .pm_hit(pm_hit),
		.dm_wr_en(dm_wr_en), .dm_rd_en(dm_rd_en), .dm_bank(dm_bank), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_hit(dm_hit),
		.mode_sel(mode_sel), .bank_sel(bank_sel),
		.gen_req(gen_req), .gen_fetch(gen_fetch), .gen_valid(gen_valid),
		.gen_item(gen_item), .gen_dots(gen_dots));

	osd_cpu_model u_osd_cpu_model (
		.clk_sys(clk_sys),
		.pm_wr_en(pm_wr_en), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
		.pm_rdata(pm_rdata), .pm_hit(pm_hit),
		.dm_wr_en(dm_wr_en), .dm_rd_en(dm_rd_en), .dm_bank(dm_bank), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .dm_hit(dm_hit));

	// ********************************
	// shared helpers
	// ********************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	// each character bit lights a pair of neighbouring dots
	function automatic logic [15:0] widen(input logic [7:0] c);
		logic [15:0] d;
		for (int i = 0; i < 8; i++) begin
			d[2 * i] = c[i];
			d[2 * i + 1] = c[i];
		end
		return d;
	endfunction

	// bounded wait: a lost answer must not hang the run
	task automatic fetch(input logic [3:0] b, input logic [3:0] k, input logic [3:0] r,
			input logic ctl);
		int n;
		n = 0;
		@(negedge clk_sys);
		gen_req = 1'b1;
		gen_fetch = '{bank: b, slot: k, row: r, ctrl_slot: ctl};
		@(negedge clk_sys);
		gen_req = 1'b0;
		gen_fetch = ~gen_fetch;
		while (gen_valid !== 1'b1 && n < 4) begin
			@(negedge clk_sys);
			n++;
		end
		check(32'(gen_valid), 32'h1, "fetch answer missing");
	endtask

	task automatic pm_chk(input logic [15:0] a, input logic [15:0] exp, input logic eh);
		u_osd_cpu_model.pm_access(1'b0, a, 16'h0000, rd16, hit);
		check(32'(rd16), 32'(exp), "store read data");
		check(32'(hit), 32'(eh), "store hit");
	endtask

	task automatic dm_chk(input logic [3:0] b, input logic [6:0] a, input logic [3:0] exp,
			input logic eh);
		u_osd_cpu_model.dm_access(1'b0, b, a, 4'h0, rd4, hit);
		check(32'(rd4), 32'(exp), "window read data");
		check(32'(hit), 32'(eh), "window hit");
	endtask

	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset();
		check(32'({pm_rdata, dm_rdata, bank_sel, pm_hit, dm_hit, gen_valid}), 32'h0, "reset");
		check(32'(gen_dots), 32'h0, "reset dots");
		$display("test reset done");
	endtask

	task automatic t_store();
		u_osd_cpu_model.define_row(8'h00, 4'h0, 8'hA5, 16'h0180);
		pm_chk(16'h3000, 16'hA501, 1'b1);
		pm_chk(16'h3001, 16'h80FF, 1'b1);
		u_osd_cpu_model.pm_access(1'b1, 16'h4FDF, 16'h1234, rd16, hit);
		pm_chk(16'h4FDF, 16'h1234, 1'b1);
		u_osd_cpu_model.pm_access(1'b1, 16'h2FFF, 16'h5555, rd16, hit);
		u_osd_cpu_model.pm_access(1'b1, 16'h4FE0, 16'h6666, rd16, hit);
		pm_chk(16'h2FFF, 16'h0000, 1'b0);
		pm_chk(16'h4FE0, 16'h0000, 1'b0);
		u_osd_cpu_model.pm_write_read(16'h3100, 16'hBEEF, rd16, hit);
		check(32'(rd16), 32'hBEEF, "store write then read");
		check(32'(hit), 32'h1, "store write then read hit");
		$display("test store done");
	endtask

	task automatic t_window();
		dm_chk(VRAM_DM_BANK, 7'h00, 4'h0, 1'b0);
		mode_sel = 4'h8;
		u_osd_cpu_model.write_item(4'h0, 4'h0, 12'h123);
		u_osd_cpu_model.write_item(4'h1, 4'h0, 12'hABC);
		check(32'(bank_sel), 32'h1, "bank select");
		for (int i = 0; i < 3; i++) begin
			dm_chk(VRAM_DM_BANK, 7'(i), 4'(4'hA + i), 1'b1);
		end
		dm_chk(VRAM_DM_BANK, BANKSEL_ADDR, 4'h1, 1'b1);
		u_osd_cpu_model.dm_access(1'b1, VRAM_DM_BANK, 7'h30, 4'hF, rd4, hit);
		dm_chk(VRAM_DM_BANK, 7'h30, 4'h0, 1'b1);
		dm_chk(VRAM_DM_BANK, 7'h3F, 4'h0, 1'b1);
		dm_chk(4'h3, 7'h00, 4'h0, 1'b0);
		u_osd_cpu_model.write_item(4'hD, 4'hF, 12'h9E7);
		dm_chk(VRAM_DM_BANK, 7'h2F, 4'h7, 1'b1);
		u_osd_cpu_model.write_item(4'hE, 4'h0, 12'hFFF);
		dm_chk(VRAM_DM_BANK, 7'h00, 4'h0, 1'b1);
		u_osd_cpu_model.dm_access(1'b1, VRAM_DM_BANK, BANKSEL_ADDR, 4'h0, rd4, hit);
		dm_chk(VRAM_DM_BANK, 7'h00, 4'h1, 1'b1);
		$display("test window done");
	endtask

	task automatic t_glyph();
		u_osd_cpu_model.define_row(8'h05, 4'h3, 8'hA5, 16'h0180);
		u_osd_cpu_model.write_item(4'h1, 4'h2, 12'h305);
		fetch(4'h1, 4'h2, 4'h3, 1'b0);
		check(32'(gen_item.cls), 32'(ITEM_GLYPH), "glyph class");
		check(32'({gen_item.colour, gen_item.glyph}), 32'h305, "colour and index");
		check(32'(gen_dots), 32'(widen(8'hA5) | 16'h0180), "row dots");
		$display("test glyph done");
	endtask

	task automatic t_class();
		logic [11:0] items [4] = '{12'h7FF, 12'h6FF, 12'h5FF, 12'h8FF};
		osd_cr_type  crs [4] = '{CR_PAGE, CR_ROW, CR_PTR, CR_NONE};
		for (int i = 0; i < 4; i++) begin
			u_osd_cpu_model.write_item(4'h2, 4'(i), items[i]);
			fetch(4'h2, 4'(i), 4'h0, 1'b0);
			check(32'(gen_item.cls), 32'((i < 3) ? ITEM_CR : ITEM_GLYPH), "class");
			check(32'(gen_item.cr), 32'(crs[i]), "return kind");
			check(32'(gen_item.ctrl2_next), 32'(i == 3), "identifier");
			check(32'(gen_dots), 32'h0, "no dots");
		end
		fetch(4'h2, 4'h0, 4'h0, 1'b1);
		check(32'(gen_item.cls), 32'(ITEM_CTRL), "control class");
		$display("test class done");
	endtask

	// ********************************
	// run control
	// ********************************
	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		t_reset();
		t_store();
		t_window();
		t_glyph();
		t_class();
		summarize();
	end

	// the whole sequence takes well under a thousand cycles
	initial begin
		#200000;
		failures++;
		summarize();
	end
endmodule // osd_char_mem_test
